// ### hdl/bpmm_cfg.svh
// Purpose: Constants for the bit processor and memory move execution unit.
// Assumes: One operation is started per request, 250 MHz sys_clk.
// Notes: Bit space is 256 bits; RAM half and special-register half.
// How it works
// - External moves address only by index or pointer
// - Accumulator alone sources or receives external data
// - Pointer constant read fetches code at acc+pointer
// - Counter constant read uses next-instruction counter plus acc
// - Constant reads never write program memory
// - Provide 128 RAM bits; of the special bits only port 0 and status (16 bits) exist
// - Bit addresses 00h-7Fh map to lower RAM
// - Bit addresses 80h-FFh map to special registers
// - Bit operations take a direct bit address only
// - Every port line is an independent addressable bit
// - Carry is accumulator and has bit address
// - Moves, set, clear, complement, AND, OR on bits
// - No exclusive-OR on carry is offered
// - Bit branches jump on one or on zero
// - Test-and-clear jumps on one and clears the bit
// - All status word bits are addressable and testable
// - Taken branch adds signed offset to the counter
// - Offset base is the byte after the branch
// - Low nibble exchange swaps only bits 3..0
// - Nibble swap exchanges accumulator halves in place
`ifndef BPMM_CFG_SVH
`define BPMM_CFG_SVH
`define BPMM_SFR_BIT_BASE 8'h80
`define BPMM_PORT0_BYTE 5'h10
`define BPMM_STATUS_BYTE 5'h1a
`define BPMM_CARRY_POS 3'h7
`define BPMM_PARITY_POS 3'h0
`define BPMM_ACC_RESET 8'h00
`define BPMM_DATA_PTR_RESET 16'h0000
`define BPMM_STATUS_RESET 8'h00
`define BPMM_PORT_RESET 8'hff
`define BPMM_IRAM_BYTES 16
`define BPMM_SFR_BYTES 16
`endif

// ### hdl/bpmm_pkg.sv
// Purpose: Types shared by the execution unit.
// Assumes: Included together with bpmm_cfg.svh.
// Notes: Operation codes are this block's own numbering.
`default_nettype none
package bpmm_pkg;
  // Operations the unit can execute
  typedef enum logic [4:0] {
    BPMM_NOP = 5'h00, BPMM_XRD_IDX = 5'h01, BPMM_XWR_IDX = 5'h02,
    BPMM_XRD_DP = 5'h03, BPMM_XWR_DP = 5'h04, BPMM_CR_DP = 5'h05,
    BPMM_CR_PC = 5'h06, BPMM_AND_C = 5'h07, BPMM_ANDN_C = 5'h08,
    BPMM_OR_C = 5'h09, BPMM_ORN_C = 5'h0a, BPMM_MOV_CB = 5'h0b,
    BPMM_MOV_BC = 5'h0c, BPMM_CLR_C = 5'h0d, BPMM_CLR_B = 5'h0e,
    BPMM_SET_C = 5'h0f, BPMM_SET_B = 5'h10, BPMM_COMP_C = 5'h11,
    BPMM_COMP_B = 5'h12, BPMM_JC = 5'h13, BPMM_JNC = 5'h14,
    BPMM_JB = 5'h15, BPMM_JNB = 5'h16, BPMM_JB_CLR = 5'h17,
    BPMM_NIB_XCHG = 5'h18, BPMM_SWAP = 5'h19, BPMM_LD_DP = 5'h1a,
    BPMM_LD_ACC = 5'h1b, BPMM_LD_IDX = 5'h1c
  } bpmm_op_t;
  // Sequencer states, Gray along idle-wait-done
  typedef enum logic [1:0] {
    BPMM_IDLE = 2'b00, BPMM_WAIT = 2'b01, BPMM_DONE = 2'b11
  } bpmm_state_t;
  // Request bundle from the instruction fetch side
  typedef struct packed {
    logic valid;
    bpmm_op_t op;
    logic [7:0] bit_addr;
    logic [7:0] rel;
    logic [15:0] pc_next;
    logic [15:0] imm;
    logic idx_sel;
  } bpmm_req_t;
  // Memory bus bundle toward external data and code memory
  typedef struct packed {
    logic xrd;
    logic xwr;
    logic crd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bpmm_mem_t;
endpackage : bpmm_pkg
`default_nettype wire

// ### hdl/bpmm_unit.sv
// Purpose: Executes external moves, constant reads, nibble ops, bit ops.
// Assumes: Memory answers with mem_ack, one request at a time.
// Notes: Port 0 is bits 0-7 of byte 10h of the bit space, the first special-register byte.
`timescale 1ns/100ps
`default_nettype none
`include "bpmm_cfg.svh"
module bpmm_unit
  import bpmm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Request and status
  input wire bpmm_req_t req,
  output bpmm_mem_t mem,
  output logic busy,
  output logic done,
  output logic jump,
  output logic [15:0] pc_out,
  // Memory answer
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  // Visible state
  output logic [7:0] acc,
  output logic [15:0] data_pointer_reg,
  output logic [7:0] port0_out,
  output logic carry
);
  // Whole module state in one struct
  typedef struct packed {
    bpmm_state_t st;
    bpmm_op_t op;
    logic [7:0] acc;
    logic [15:0] data_ptr; // Table base and wide external pointer
    logic [7:0] idx0;
    logic [7:0] idx1;
    logic [127:0] ram_bits;
    logic [7:0] status;
    logic [7:0] port0;
    logic [7:0] nib_cell;
    bpmm_mem_t mem;
    logic done;
    logic jump;
    logic [15:0] pc;
    logic busy; // Registered so the status pin comes from a flop
  } bpmm_st_t;

  bpmm_st_t s_reg;
  bpmm_st_t s_next;

  // Read a bit from the combined 256-bit space
  function automatic logic bit_rd(input bpmm_st_t s, input logic [7:0] a);
    logic r;
    r = 1'b0;
    if (a < `BPMM_SFR_BIT_BASE) begin
      r = s.ram_bits[a[6:0]];
    end else if (a[7:3] == `BPMM_PORT0_BYTE) begin
      r = s.port0[a[2:0]];
    end else if (a[7:3] == `BPMM_STATUS_BYTE) begin
      r = s.status[a[2:0]];
    end
    return r;
  endfunction : bit_rd

  // Write a bit in the combined space; unmapped special bits are dropped
  function automatic bpmm_st_t bit_wr(input bpmm_st_t s,
                                      input logic [7:0] a, input logic v);
    bpmm_st_t r;
    r = s;
    if (a < `BPMM_SFR_BIT_BASE) begin
      r.ram_bits[a[6:0]] = v;
    end else if (a[7:3] == `BPMM_PORT0_BYTE) begin
      r.port0[a[2:0]] = v;
    end else if (a[7:3] == `BPMM_STATUS_BYTE) begin
      r.status[a[2:0]] = v;
    end
    return r;
  endfunction : bit_wr

  // Signed offset added to the following-instruction address
  function automatic logic [15:0] rel_tgt(input logic [15:0] pc,
                                          input logic [7:0] off);
    return pc + {{8{off[7]}}, off};
  endfunction : rel_tgt

  // Next-state logic
  always_comb begin
    logic b;
    logic c;
    logic [7:0] ix;
    s_next = s_reg;
    b = bit_rd(s_reg, req.bit_addr);
    c = s_reg.status[`BPMM_CARRY_POS];
    ix = req.idx_sel ? s_reg.idx1 : s_reg.idx0;
    s_next.done = 1'b0;
    s_next.jump = 1'b0;
    case (s_reg.st)
      BPMM_IDLE: begin
        if (req.valid) begin
          s_next.op = req.op;
          s_next.pc = req.pc_next;
          s_next.st = BPMM_DONE;
          case (req.op)
            // Byte-address external moves use the index register
            BPMM_XRD_IDX, BPMM_XWR_IDX: begin
              s_next.mem.addr = {8'h00, ix};
              s_next.mem.xrd = (req.op == BPMM_XRD_IDX);
              s_next.mem.xwr = (req.op == BPMM_XWR_IDX);
              s_next.mem.wdata = s_reg.acc;
              s_next.st = BPMM_WAIT;
            end
            BPMM_XRD_DP, BPMM_XWR_DP: begin
              s_next.mem.addr = s_reg.data_ptr;
              s_next.mem.xrd = (req.op == BPMM_XRD_DP);
              s_next.mem.xwr = (req.op == BPMM_XWR_DP);
              s_next.mem.wdata = s_reg.acc;
              s_next.st = BPMM_WAIT;
            end
            // Constant reads only ever raise the read strobe
            BPMM_CR_DP: begin
              s_next.mem.addr = s_reg.data_ptr +
                {8'h00, s_reg.acc};
              s_next.mem.crd = 1'b1;
              s_next.st = BPMM_WAIT;
            end
            BPMM_CR_PC: begin
              s_next.mem.addr = req.pc_next + {8'h00, s_reg.acc};
              s_next.mem.crd = 1'b1;
              s_next.st = BPMM_WAIT;
            end
            // Carry and bit logic; no exclusive-OR form exists
            BPMM_AND_C: s_next.status[`BPMM_CARRY_POS] = c & b;
            BPMM_ANDN_C: s_next.status[`BPMM_CARRY_POS] = c & ~b;
            BPMM_OR_C: s_next.status[`BPMM_CARRY_POS] = c | b;
            BPMM_ORN_C: s_next.status[`BPMM_CARRY_POS] = c | ~b;
            BPMM_MOV_CB: s_next.status[`BPMM_CARRY_POS] = b;
            BPMM_MOV_BC: s_next = bit_wr(s_next, req.bit_addr, c);
            BPMM_CLR_C: s_next.status[`BPMM_CARRY_POS] = 1'b0;
            BPMM_CLR_B: s_next = bit_wr(s_next, req.bit_addr, 1'b0);
            BPMM_SET_C: s_next.status[`BPMM_CARRY_POS] = 1'b1;
            BPMM_SET_B: s_next = bit_wr(s_next, req.bit_addr, 1'b1);
            BPMM_COMP_C: s_next.status[`BPMM_CARRY_POS] = ~c;
            BPMM_COMP_B: s_next = bit_wr(s_next, req.bit_addr, ~b);
            // Bit-test branches
            BPMM_JC: s_next.jump = c;
            BPMM_JNC: s_next.jump = ~c;
            BPMM_JB: s_next.jump = b;
            BPMM_JNB: s_next.jump = ~b;
            BPMM_JB_CLR: begin
              s_next.jump = b;
              if (b) begin
                s_next = bit_wr(s_next, req.bit_addr, 1'b0);
              end
            end
            // Nibble exchange with the single nibble cell loaded by BPMM_LD_IDX
            BPMM_NIB_XCHG: begin
              s_next.acc = {s_reg.acc[7:4], s_reg.nib_cell[3:0]};
              s_next.nib_cell = {s_reg.nib_cell[7:4], s_reg.acc[3:0]};
            end
            BPMM_SWAP: s_next.acc = {s_reg.acc[3:0], s_reg.acc[7:4]};
            BPMM_LD_DP: s_next.data_ptr = req.imm;
            BPMM_LD_ACC: s_next.acc = req.imm[7:0];
            BPMM_LD_IDX: begin
              // Also preload the nibble cell from the upper immediate byte
              if (req.idx_sel) begin
                s_next.idx1 = req.imm[7:0];
              end else begin
                s_next.idx0 = req.imm[7:0];
              end
              s_next.nib_cell = req.imm[15:8];
            end
            default: s_next.st = BPMM_DONE;
          endcase
          // Branch target computed from the following-instruction address
          if (s_next.jump) begin
            s_next.pc = rel_tgt(req.pc_next, req.rel);
          end
        end
      end
      BPMM_WAIT: begin
        // Hold the strobe until memory answers
        if (mem_ack) begin
          if (s_reg.mem.xrd || s_reg.mem.crd) begin
            s_next.acc = mem_rdata;
          end
          s_next.mem.xrd = 1'b0;
          s_next.mem.xwr = 1'b0;
          s_next.mem.crd = 1'b0;
          s_next.st = BPMM_DONE;
        end
      end
      BPMM_DONE: begin
        s_next.done = 1'b1;
        s_next.st = BPMM_IDLE;
      end
      default: s_next.st = BPMM_IDLE;
    endcase
    // Parity bit tracks the accumulator
    s_next.status[`BPMM_PARITY_POS] = ^s_next.acc;
    // Busy follows the next state so the pin needs no decode after the flop
    s_next.busy = (s_next.st != BPMM_IDLE);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.acc <= `BPMM_ACC_RESET;
      s_reg.data_ptr <= `BPMM_DATA_PTR_RESET;
      s_reg.status <= `BPMM_STATUS_RESET;
      s_reg.port0 <= `BPMM_PORT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign mem = s_reg.mem;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign jump = s_reg.jump;
  assign pc_out = s_reg.pc;
  assign acc = s_reg.acc;
  assign data_pointer_reg = s_reg.data_ptr;
  assign port0_out = s_reg.port0;
  assign carry = s_reg.status[`BPMM_CARRY_POS];

  // Checks, kept beside the behaviour of this module that they guard
  // Constant reads raise only the read strobe, never a write
  a_const_no_write: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mem.crd |-> !mem.xwr)
    else $error("Constant read wrote memory");
  // Byte-address external reads keep the high address byte at zero
  a_ext_idx_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_XRD_IDX)
    |=> mem.addr[15:8] == 8'h00)
    else $error("Index address high");
  // Write data is the accumulator as it stood when the move was taken
  a_ext_wr_acc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(mem.xwr) |-> mem.wdata == $past(acc))
    else $error("Write data not acc");
  // Pointer table read addresses pointer plus accumulator
  a_ptr_code_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_CR_DP)
    |=> mem.crd && mem.addr == $past(data_pointer_reg) +
    {8'h00, $past(acc)})
    else $error("Pointer table address wrong");
  // Counter table read uses the following-instruction address as base
  a_pc_code_addr: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_CR_PC)
    |=> mem.crd && mem.addr == $past(req.pc_next) + {8'h00, $past(acc)})
    else $error("Counter table address wrong");
  // Nibble swap trades the accumulator halves
  a_swap_halves: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_SWAP)
    |=> acc == {$past(acc[3:0]), $past(acc[7:4])})
    else $error("Swap wrong");
  // Low nibble exchange never touches the upper half
  a_nib_xchg_high: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_NIB_XCHG)
    |=> acc[7:4] == $past(acc[7:4]))
    else $error("High nibble moved");
  // Lower bit addresses land in the RAM bit page
  a_ram_bit_set: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_SET_B &&
    !req.bit_addr[7])
    |=> s_reg.ram_bits[$past(req.bit_addr[6:0])])
    else $error("RAM bit not set");
  // A port line takes the carry like any other bit
  a_port_bit_move: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_MOV_BC &&
    req.bit_addr[7:3] == `BPMM_PORT0_BYTE)
    |=> port0_out[$past(req.bit_addr[2:0])] == $past(carry))
    else $error("Port line not moved");
  // Carry set operation
  a_set_carry_one: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_SET_C)
    |=> carry)
    else $error("Carry not set");
  // An OR with carry already set keeps it set; an XOR form would not
  a_or_keeps_carry: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_OR_C && carry)
    |=> carry)
    else $error("OR cleared carry");
  // Carry branch follows the carry
  a_jc_taken: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_JC)
    |=> jump == $past(carry))
    else $error("Carry jump wrong");
  // A branch not taken leaves the following-instruction address
  a_no_jump_held: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_JNC && carry)
    |=> !jump && pc_out == $past(req.pc_next))
    else $error("Untaken branch moved");
  // Taken branch adds the sign-extended offset
  a_jump_target: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_JNC && !carry)
    |=> pc_out == $past(req.pc_next) + {{8{$past(req.rel[7])}},
    $past(req.rel)})
    else $error("Target wrong");
  // Completion follows the memory answer by two cycles
  a_done_follows: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_WAIT && mem_ack) |=> ##1 done)
    else $error("Done missing");
  // Test-and-clear leaves a RAM bit cleared
  a_test_clear_bit: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (s_reg.st == BPMM_IDLE && req.valid && req.op == BPMM_JB_CLR &&
    !req.bit_addr[7])
    |=> !s_reg.ram_bits[$past(req.bit_addr[6:0])])
    else $error("Tested bit left set");
endmodule : bpmm_unit
`default_nettype wire

// ### tb/bpmm_mem_model.sv
// Purpose: External data RAM and code memory behind the unit.
// Assumes: Strobes held until mem_ack, ack is a one-cycle level.
// Notes: slow adds three wait cycles; idle read bus toggles.
`timescale 1ns/100ps
`default_nettype none
module bpmm_mem_model
  import bpmm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus from the unit
  input wire bpmm_mem_t mem,
  input wire logic slow,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  // Observation for the bench
  output logic [15:0] last_waddr,
  output logic [7:0] last_wdata,
  output logic [15:0] last_caddr,
  output logic [7:0] xwr_cnt
);
  logic [7:0] xram [0:255]; // Only the low address byte decodes
  logic [1:0] dly; // Wait-state counter
  // One access at a time; read bus shows junk when not answering
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      dly <= 2'h0;
      xwr_cnt <= 8'h00;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata; // Stale data must not look valid
      if ((mem.xrd | mem.xwr | mem.crd) && !mem_ack) begin
        if (dly != (slow ? 2'h3 : 2'h0)) begin
          dly <= dly + 2'h1;
        end else begin
          dly <= 2'h0;
          mem_ack <= 1'b1;
          if (mem.xwr) begin
            xram[mem.addr[7:0]] <= mem.wdata;
            last_waddr <= mem.addr;
            last_wdata <= mem.wdata;
            xwr_cnt <= xwr_cnt + 8'h01;
          end else if (mem.crd) begin
            mem_rdata <= mem.addr[7:0] ^ mem.addr[15:8] ^ 8'h5a;
            last_caddr <= mem.addr;
          end else begin
            mem_rdata <= xram[mem.addr[7:0]];
          end
        end
      end
    end
  end
endmodule : bpmm_mem_model
`default_nettype wire

// ### tb/test_bit_processor_and_memory_moves.sv
// Purpose: Self-checking bench for the bit and memory move unit.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Each scenario task drives and judges its own traffic.
`timescale 1ns/100ps
`default_nettype none
module test_bit_processor_and_memory_moves;
  import bpmm_pkg::*;
  logic sys_clk, rst_b, slow, mem_ack, busy, done, jump, carry, jseen;
  bpmm_req_t req;
  bpmm_mem_t mem;
  logic [15:0] pc_out, data_pointer_reg, last_waddr, last_caddr;
  logic [7:0] mem_rdata, acc, port0_out, last_wdata, xwr_cnt, n;
  int error_cnt = 0;
  int checks = 0;
  bpmm_unit bpmm_unit_i (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
    .mem(mem), .busy(busy), .done(done), .jump(jump), .pc_out(pc_out),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc(acc),
    .data_pointer_reg(data_pointer_reg), .port0_out(port0_out),
    .carry(carry));
  bpmm_mem_model bpmm_mem_model_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .mem(mem), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .last_waddr(last_waddr), .last_wdata(last_wdata),
    .last_caddr(last_caddr), .xwr_cnt(xwr_cnt));
  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One request; returns in the idle cycle after done, jump captured
  task automatic op(input bpmm_op_t o, input logic [7:0] ba = 8'h00,
    input logic [7:0] rl = 8'h00, input logic [15:0] im = 16'h0000,
    input logic [15:0] pcn = 16'h4000, input logic ixs = 1'b0);
    req = '{valid: 1'b1, op: o, bit_addr: ba, rel: rl, pc_next: pcn,
      imm: im, idx_sel: ixs};
    jseen = 1'b0;
    @(posedge sys_clk);
    #1 req.valid = 1'b0;
    for (int i = 0; i < 40 && done !== 1'b1; i++) begin
      if (jump === 1'b1) jseen = 1'b1;
      @(posedge sys_clk);
      #1;
    end
    if (done !== 1'b1) begin
      error_cnt++; // Hang: no completion within bound
      report_and_stop();
    end
    @(posedge sys_clk);
    #1;
  endtask : op
  task automatic t_ext();
    slow = 1'b1; // Memory stalls the first two writes; the reads and the idx1 write below run fast
    op(BPMM_LD_ACC, , , 16'h00a5);
    op(BPMM_LD_IDX, , , 16'h0033);
    op(BPMM_XWR_IDX);
    check("idx addr", last_waddr, 16'h0033);
    check("idx data", last_wdata, 8'ha5);
    op(BPMM_LD_DP, , , 16'h1234);
    op(BPMM_LD_ACC, , , 16'h003c);
    op(BPMM_XWR_DP);
    check("dp addr", last_waddr, 16'h1234);
    op(BPMM_LD_ACC, , , 16'h0000);
    slow = 1'b0;
    op(BPMM_XRD_DP);
    check("dp read", acc, 8'h3c);
    op(BPMM_XRD_IDX);
    check("idx read", acc, 8'ha5);
    op(BPMM_LD_IDX, , , 16'h0077, , 1'b1); // Second index register
    op(BPMM_XWR_IDX, , , , , 1'b1);
    check("idx1 addr", last_waddr, 16'h0077);
    check("idx1 data", last_wdata, 8'ha5);
  endtask : t_ext
  task automatic t_code();
    n = xwr_cnt;
    op(BPMM_LD_DP, , , 16'h10f0);
    op(BPMM_LD_ACC, , , 16'h00ff);
    op(BPMM_CR_DP);
    check("dp code addr", last_caddr, 16'h11ef);
    check("dp code", acc, 8'h11 ^ 8'hef ^ 8'h5a);
    op(BPMM_LD_ACC, , , 16'h0005);
    op(BPMM_CR_PC, , , , 16'h2000);
    check("pc code", acc, 8'h20 ^ 8'h05 ^ 8'h5a);
    check("no writes", xwr_cnt, n);
  endtask : t_code
  task automatic t_bits();
    bpmm_op_t seq [12] = '{BPMM_SET_C, BPMM_COMP_C, BPMM_SET_B, BPMM_OR_C,
      BPMM_ANDN_C, BPMM_COMP_C, BPMM_AND_C, BPMM_CLR_B, BPMM_AND_C,
      BPMM_ORN_C, BPMM_CLR_C, BPMM_MOV_CB};
    logic [11:0] exp = 12'b100101110100; // Carry after each step
    foreach (seq[i]) begin
      op(seq[i], 8'h05);
      check("carry", carry, exp[11-i]);
    end
    op(BPMM_MOV_BC, 8'h83);
    check("port", port0_out, 8'hf7);
    op(BPMM_SET_B, 8'h7f);
    op(BPMM_MOV_CB, 8'h7f);
    check("ram bit", {port0_out, 7'h00, carry}, 16'hf701);
    op(BPMM_OR_C, 8'h7f); // One OR one stays one; an XOR would clear it
    check("or carry", carry, 1'b1);
    op(BPMM_COMP_B, 8'h83);
    check("port comp", port0_out, 8'hff);
    op(BPMM_CLR_B, 8'hd7);
    check("carry addr", carry, 1'b0);
  endtask : t_bits
  task automatic br(input bpmm_op_t o, input logic [7:0] ba, rl,
    input logic tk);
    op(o, ba, rl);
    check("jump", jseen, tk);
    check("target", pc_out, tk ? 16'h4000 + {{8{rl[7]}}, rl} :
      16'h4000);
  endtask : br
  task automatic t_branch();
    op(BPMM_SET_C);
    br(BPMM_JC, 8'h00, 8'h80, 1'b1);
    br(BPMM_JNC, 8'h00, 8'h7f, 1'b0);
    op(BPMM_CLR_C);
    br(BPMM_JNC, 8'h00, 8'h7f, 1'b1);
    op(BPMM_SET_B, 8'h20);
    br(BPMM_JB, 8'h20, 8'hfe, 1'b1);
    br(BPMM_JNB, 8'h20, 8'h05, 1'b0);
    br(BPMM_JB_CLR, 8'h20, 8'h10, 1'b1);
    br(BPMM_JB, 8'h20, 8'h10, 1'b0);
    op(BPMM_LD_ACC, , , 16'h0001);
    br(BPMM_JB, 8'hd0, 8'h04, 1'b1);
  endtask : t_branch
  task automatic t_nibble();
    op(BPMM_LD_ACC, , , 16'h0078);
    op(BPMM_LD_IDX, , , 16'h5600);
    op(BPMM_NIB_XCHG);
    check("nib xchg", acc, 8'h76);
    op(BPMM_SWAP);
    check("swap", acc, 8'h67);
    op(BPMM_NIB_XCHG);
    check("nib xchg back", acc, 8'h68);
  endtask : t_nibble
  // Main sequence: reset, then every scenario
  initial begin
    req = '0;
    slow = 1'b0;
    rst_b = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    check("reset", {acc, port0_out}, 16'h00ff);
    check("reset dp", {data_pointer_reg[14:0], busy}, 16'h0000);
    t_ext();
    t_code();
    t_bits();
    t_branch();
    t_nibble();
    report_and_stop();
  end
endmodule : test_bit_processor_and_memory_moves
`default_nettype wire
